// *** logic/nfa_channel.sv ***
/*
  One adjust channel: control byte, four-byte staged offset word, and the
  applied offset and adjusted frequency. Assumes a one-cycle update tick
  from the parent and synchronous byte writes.
*/
`timescale 1ns/1ps
`include "nfa_regs.svh"

module nfa_channel #(
  parameter logic [7:0] BASE = `NFA_CHAN_A_CTRL,
  parameter int         FW   = 32
) (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic                 wr,
  input  wire logic [7:0]           addr,
  input  wire logic [7:0]           wdata,
  input  wire logic                 tick,
  input  wire logic [3:0][FW-1:0]   finit,
  output logic      [7:0]           rdata,
  output logic      [2:0]           ctrl_q,
  output logic      [31:0]          offset_q,
  output logic      [FW-1:0]        freq_q
);

  logic [31:0]        shadow_q;
  logic [31:0]        shadow_d;
  logic [31:0]        word_q;
  logic [3:0]         seen_q;
  logic [31:0]        eff_offset;
  logic [FW+32:0]     prod;
  logic [FW+32:0]     delta;

  wire [7:0]          rel     = addr - BASE;
  wire                hit_ctrl = (rel == 8'h00);
  wire                hit_off  = (rel >= 8'h01) && (rel <= 8'h04);
  wire [1:0]          bidx     = rel[1:0] - 2'h1;
  wire [3:0]          bit_sel  = 4'h1 << bidx;
  wire                wr_off   = wr && hit_off;
  wire                commit   = wr_off && ((seen_q | bit_sel) == 4'hF);
  wire [FW-1:0]       fsel     = finit[ctrl_q[`NFA_CTRL_SEL_MSB:`NFA_CTRL_SEL_LSB]];

  // Most significant byte sits at the lowest offset address
  always_comb begin
    shadow_d = shadow_q;
    if (wr_off) begin
      shadow_d[8*(3-bidx) +: 8] = wdata;
    end
  end

  // Disabled channel, or all-zero control, contributes no offset
  assign eff_offset = ctrl_q[`NFA_CTRL_EN_BIT] ? word_q : `NFA_OFFSET_RESET;
  // fout = finit * (1 + X / 2^32), X signed
  assign prod  = $signed({1'b0, fsel}) * $signed(eff_offset);
  assign delta = $signed(prod) >>> 32;
  assign rdata = hit_ctrl ? {5'h00, ctrl_q} :
                 hit_off  ? word_q[8*(3-bidx) +: 8] : 8'h00;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= `NFA_CTRL_RESET;
    end else if (wr && hit_ctrl) begin
      ctrl_q <= wdata[2:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shadow_q <= `NFA_OFFSET_RESET;
      seen_q   <= 4'h0;
      word_q   <= `NFA_OFFSET_RESET;
    end else begin
      shadow_q <= shadow_d;
      seen_q   <= commit ? 4'h0 : (wr_off ? (seen_q | bit_sel) : seen_q);
      if (commit) begin
        word_q <= shadow_d;
      end
    end
  end

  // New offsets reach the synthesizer only on the update tick
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      offset_q <= `NFA_OFFSET_RESET;
      freq_q   <= '0;
    end else if (tick) begin
      offset_q <= eff_offset;
      freq_q   <= fsel + delta[FW-1:0];
    end
  end

  commit_needs_all_a : assert property (@(posedge clk) disable iff (!nrst)
    (word_q != $past(word_q)) |-> $past(commit))
    else $error("offset word changed without a full four-byte write");

  off_when_idle_a : assert property (@(posedge clk) disable iff (!nrst)
    (tick && (ctrl_q == 3'h0)) |=> (offset_q == 32'h0000_0000))
    else $error("offset applied while control is zero");

  tick_only_a : assert property (@(posedge clk) disable iff (!nrst)
    !tick |=> $stable(offset_q) && $stable(freq_q))
    else $error("applied value moved outside an update tick");

  applies_word_a : assert property (@(posedge clk) disable iff (!nrst)
    (tick && ctrl_q[0]) |=> (offset_q == $past(word_q)))
    else $error("enabled channel did not apply its offset word");

endmodule : nfa_channel

// *** logic/nfa_pkg.sv ***
/*
  Types of the fine frequency adjust block.
  Assumes nfa_regs.svh supplies the numeric constants.
*/
package nfa_pkg;

  typedef enum logic [1:0] {
    NFA_TGT_DPLL0 = 2'b00,
    NFA_TGT_DPLL1 = 2'b01,
    NFA_TGT_OSC2  = 2'b10,
    NFA_TGT_OSC3  = 2'b11
  } nfa_target_type;

endpackage : nfa_pkg

// *** logic/nfa_regs.svh ***
/*
  Register offsets, field positions, reset values and timing counts of the
  fine frequency adjust block. Assumes an 8-bit byte-addressed register port.
*/
`ifndef NFA_REGS_SVH
`define NFA_REGS_SVH

`define NFA_CHAN_A_CTRL      8'hEC
`define NFA_CHAN_A_OFFSET    8'hED
`define NFA_CHAN_B_CTRL      8'hF1
`define NFA_CHAN_B_OFFSET    8'hF2
`define NFA_OFFSET_BYTES     4

`define NFA_CTRL_EN_BIT      0
`define NFA_CTRL_SEL_LSB     1
`define NFA_CTRL_SEL_MSB     2
`define NFA_CTRL_RESET       3'h0
`define NFA_OFFSET_RESET     32'h0000_0000

`define NFA_UPDATE_NS        300000
`define NFA_CLK_PERIOD_NS    100
`define NFA_UPDATE_CYCLES    (`NFA_UPDATE_NS / `NFA_CLK_PERIOD_NS)

`endif

// *** logic/nfa_top.sv ***
/*
  Fine frequency adjust for two oscillator channels, a and b, behind an
  8-bit register port. Assumes finit inputs carry each synthesizer's nominal
  frequency word from the divider settings, and synchronous inputs.
*/
`timescale 1ns/1ps
`include "nfa_regs.svh"

module nfa_top #(
  parameter int FW         = 32,
  parameter int UPD_CYCLES = `NFA_UPDATE_CYCLES
) (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic                 reg_wr,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  output logic      [7:0]           reg_rdata_q,
  input  wire logic [3:0][FW-1:0]   finit,
  output logic                      chan_a_fine_adjust_enable_q,
  output nfa_pkg::nfa_target_type   chan_a_target_select_q,
  output logic      [31:0]          chan_a_offset_word_q,
  output logic      [FW-1:0]        chan_a_freq_q,
  output logic                      chan_b_fine_adjust_enable_q,
  output nfa_pkg::nfa_target_type   chan_b_target_select_q,
  output logic      [31:0]          chan_b_offset_word_q,
  output logic      [FW-1:0]        chan_b_freq_q,
  output logic      [1:0]           dpll_nco_mode_q,
  output logic                      target_clash_q,
  output logic                      update_tick_q
);

  logic [11:0]   tick_cnt_q;
  logic [7:0]    rdata_a;
  logic [7:0]    rdata_b;
  logic [2:0]    ctrl_a;
  logic [2:0]    ctrl_b;

  wire           tick_now = (tick_cnt_q == 12'(UPD_CYCLES - 1));
  wire [1:0]     sel_a    = ctrl_a[`NFA_CTRL_SEL_MSB:`NFA_CTRL_SEL_LSB];
  wire [1:0]     sel_b    = ctrl_b[`NFA_CTRL_SEL_MSB:`NFA_CTRL_SEL_LSB];
  wire           en_a     = ctrl_a[`NFA_CTRL_EN_BIT];
  wire           en_b     = ctrl_b[`NFA_CTRL_EN_BIT];
  wire [1:0]     nco_d;
  // Misprogramming is only flagged; both channels still act on it
  wire           clash_d  = en_a && en_b && (sel_a == sel_b);

  assign nco_d[0] = (en_a && sel_a == 2'(nfa_pkg::NFA_TGT_DPLL0)) ||
                    (en_b && sel_b == 2'(nfa_pkg::NFA_TGT_DPLL0));
  assign nco_d[1] = (en_a && sel_a == 2'(nfa_pkg::NFA_TGT_DPLL1)) ||
                    (en_b && sel_b == 2'(nfa_pkg::NFA_TGT_DPLL1));

  // Free-running update timer shared by both channels
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_q    <= 12'h000;
      update_tick_q <= 1'b0;
    end else begin
      tick_cnt_q    <= tick_now ? 12'h000 : tick_cnt_q + 12'h001;
      update_tick_q <= tick_now;
    end
  end

  nfa_channel #(.BASE(`NFA_CHAN_A_CTRL), .FW(FW)) u_chan_a (
    .clk      (clk),
    .nrst     (nrst),
    .wr       (reg_wr),
    .addr     (reg_addr),
    .wdata    (reg_wdata),
    .tick     (tick_now),
    .finit    (finit),
    .rdata    (rdata_a),
    .ctrl_q   (ctrl_a),
    .offset_q (chan_a_offset_word_q),
    .freq_q   (chan_a_freq_q)
  );

  nfa_channel #(.BASE(`NFA_CHAN_B_CTRL), .FW(FW)) u_chan_b (
    .clk      (clk),
    .nrst     (nrst),
    .wr       (reg_wr),
    .addr     (reg_addr),
    .wdata    (reg_wdata),
    .tick     (tick_now),
    .finit    (finit),
    .rdata    (rdata_b),
    .ctrl_q   (ctrl_b),
    .offset_q (chan_b_offset_word_q),
    .freq_q   (chan_b_freq_q)
  );

  // Outputs re-registered so every top port comes from a flop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_q                 <= 8'h00;
      chan_a_fine_adjust_enable_q <= 1'b0;
      chan_b_fine_adjust_enable_q <= 1'b0;
      chan_a_target_select_q      <= nfa_pkg::NFA_TGT_DPLL0;
      chan_b_target_select_q      <= nfa_pkg::NFA_TGT_DPLL0;
      dpll_nco_mode_q             <= 2'h0;
      target_clash_q              <= 1'b0;
    end else begin
      reg_rdata_q                 <= rdata_a | rdata_b;
      chan_a_fine_adjust_enable_q <= en_a;
      chan_b_fine_adjust_enable_q <= en_b;
      chan_a_target_select_q      <= nfa_pkg::nfa_target_type'(sel_a);
      chan_b_target_select_q      <= nfa_pkg::nfa_target_type'(sel_b);
      dpll_nco_mode_q             <= nco_d;
      target_clash_q              <= clash_d;
    end
  end

  sequence tick_seen_s;
    update_tick_q;
  endsequence

  sequence quiet_after_s;
    !update_tick_q [*8];
  endsequence

  tick_spacing_a : assert property (@(posedge clk) disable iff (!nrst)
    tick_seen_s |=> quiet_after_s)
    else $error("update ticks closer than expected");

  tick_period_a : assert property (@(posedge clk) disable iff (!nrst)
    update_tick_q |-> (tick_cnt_q == 12'h000))
    else $error("update tick out of step with its timer");

  dpll_mode_a : assert property (@(posedge clk) disable iff (!nrst)
    (en_a && sel_a == 2'b01) |=> dpll_nco_mode_q[1])
    else $error("selected DPLL1 not put in oscillator mode");

  dpll_idle_a : assert property (@(posedge clk) disable iff (!nrst)
    (!en_a && !en_b) |=> (dpll_nco_mode_q == 2'h0))
    else $error("DPLL in oscillator mode with both channels off");

  ctrl_readback_a : assert property (@(posedge clk) disable iff (!nrst)
    (reg_addr == 8'hEC) |=> (reg_rdata_q == {5'h00, $past(ctrl_a)}))
    else $error("channel a control readback wrong");

  ctrl_b_readback_a : assert property (@(posedge clk) disable iff (!nrst)
    (reg_addr == `NFA_CHAN_B_CTRL) |=> (reg_rdata_q == {5'h00, $past(ctrl_b)}))
    else $error("channel b control readback wrong");

  // Write to output is two edges: control flop, then output flop
  sequence ctrl_a_write_s;
    reg_wr && (reg_addr == `NFA_CHAN_A_CTRL);
  endsequence

  sequence ctrl_b_write_s;
    reg_wr && (reg_addr == `NFA_CHAN_B_CTRL);
  endsequence

  en_a_follow_a : assert property (@(posedge clk) disable iff (!nrst)
    ctrl_a_write_s |=> ##1 (chan_a_fine_adjust_enable_q == $past(reg_wdata[`NFA_CTRL_EN_BIT], 2)))
    else $error("channel a enable output did not follow its write");

  sel_a_follow_a : assert property (@(posedge clk) disable iff (!nrst)
    ctrl_a_write_s |=> ##1 (chan_a_target_select_q == $past(reg_wdata[`NFA_CTRL_SEL_MSB:`NFA_CTRL_SEL_LSB], 2)))
    else $error("channel a select output did not follow its write");

  en_b_follow_a : assert property (@(posedge clk) disable iff (!nrst)
    ctrl_b_write_s |=> ##1 (chan_b_fine_adjust_enable_q == $past(reg_wdata[`NFA_CTRL_EN_BIT], 2)))
    else $error("channel b enable output did not follow its write");

  sel_b_follow_a : assert property (@(posedge clk) disable iff (!nrst)
    ctrl_b_write_s |=> ##1 (chan_b_target_select_q == $past(reg_wdata[`NFA_CTRL_SEL_MSB:`NFA_CTRL_SEL_LSB], 2)))
    else $error("channel b select output did not follow its write");

  dpll0_mode_a : assert property (@(posedge clk) disable iff (!nrst)
    ((en_a && sel_a == 2'h0) || (en_b && sel_b == 2'h0)) |=> dpll_nco_mode_q[0])
    else $error("selected DPLL0 not put in oscillator mode");

  dpll1_any_a : assert property (@(posedge clk) disable iff (!nrst)
    ((en_a && sel_a == 2'h1) || (en_b && sel_b == 2'h1)) |=> dpll_nco_mode_q[1])
    else $error("DPLL1 chosen by a channel not put in oscillator mode");

  osc_no_dpll_a : assert property (@(posedge clk) disable iff (!nrst)
    (!(en_a && !sel_a[1]) && !(en_b && !sel_b[1])) |=> (dpll_nco_mode_q == 2'h0))
    else $error("DPLL in oscillator mode while no channel selects one");

  clash_flag_a : assert property (@(posedge clk) disable iff (!nrst)
    1'b1 |=> (target_clash_q == $past(en_a && en_b && (sel_a == sel_b))))
    else $error("target clash flag wrong");

  // Disabled channel must hand the nominal word through untouched
  a_off_freq_a : assert property (@(posedge clk) disable iff (!nrst)
    (tick_now && !en_a) |=> (chan_a_freq_q == $past(finit[sel_a])))
    else $error("disabled channel a frequency not nominal");

  b_off_freq_a : assert property (@(posedge clk) disable iff (!nrst)
    (tick_now && !en_b) |=> (chan_b_freq_q == $past(finit[sel_b])))
    else $error("disabled channel b frequency not nominal");

  // Checking aid only: edges since the last tick, kept apart from the timer
  logic [11:0]   tick_gap_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick_gap_q <= 12'h000;
    end else begin
      tick_gap_q <= update_tick_q ? 12'h001 : tick_gap_q + 12'h001;
    end
  end

  tick_gap_a : assert property (@(posedge clk) disable iff (!nrst)
    update_tick_q |-> (tick_gap_q == 12'(UPD_CYCLES)))
    else $error("update tick period wrong");

  tick_bound_a : assert property (@(posedge clk) disable iff (!nrst)
    (tick_cnt_q < 12'(UPD_CYCLES)))
    else $error("update timer beyond its period");

endmodule : nfa_top

// *** testbench/nco_fine_frequency_adjust_tb.sv ***
/* Self-checking bench of nfa_top: byte writes and reads on the register port,
   update ticks, applied offsets and frequencies. Assumes logic/ on include path. */
`timescale 1ns/1ps
`include "nfa_regs.svh"

module nco_fine_frequency_adjust_tb;
  localparam int UPD = 16;
  logic                    clk, nrst, reg_wr, a_en_q, b_en_q, clash_q, update_tick_q;
  logic [7:0]              reg_addr, reg_wdata, reg_rdata_q, rd;
  logic [3:0][31:0]        finit;
  nfa_pkg::nfa_target_type a_sel_q, b_sel_q;
  logic [31:0]             a_off_q, b_off_q, a_freq_q, b_freq_q;
  logic [1:0]              nco_q;
  int                      err_total, cmp_count, cyc;

  nfa_top #(.FW(32), .UPD_CYCLES(UPD)) DUT (
    .clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_q(reg_rdata_q), .finit(finit),
    .chan_a_fine_adjust_enable_q(a_en_q), .chan_a_target_select_q(a_sel_q),
    .chan_a_offset_word_q(a_off_q), .chan_a_freq_q(a_freq_q),
    .chan_b_fine_adjust_enable_q(b_en_q), .chan_b_target_select_q(b_sel_q),
    .chan_b_offset_word_q(b_off_q), .chan_b_freq_q(b_freq_q),
    .dpll_nco_mode_q(nco_q), .target_clash_q(clash_q), .update_tick_q(update_tick_q));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic give_verdict;
    $display("TB: %0d comparisons, %0d mismatches", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rdb(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    @(posedge clk);
    #1 rd = reg_rdata_q;
  endtask : rdb

  // Control outputs need ctrl flop plus output flop
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic wait_tick;
    for (int i = 0; i < UPD + 4; i++) begin
      @(posedge clk);
      #1;
      if (update_tick_q === 1'b1) break;
    end
    chk("update_tick", {31'h0, update_tick_q}, 32'h1);
  endtask : wait_tick

  // Floor of the signed product, as the frequency path rounds
  function automatic logic [31:0] exp_freq(input logic [31:0] f, input logic [31:0] x);
    longint p;
    p = longint'(f) * longint'($signed(x));
    return f + 32'(p >>> 32);
  endfunction : exp_freq

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      give_verdict();
    end
  end

  initial begin
    nrst = 1'b0; reg_wr = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
    err_total = 0; cmp_count = 0; cyc = 0;
    finit = {32'h1000_0000, 32'h0800_0000, 32'h0400_0000, 32'h0200_0000};
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    for (int a = 'hEC; a <= 'hF5; a++) begin
      rdb(8'(a));
      chk("reset_read", {24'h0, rd}, 32'h0);
    end
    $display("TB: reset values done");
    wr(`NFA_CHAN_A_CTRL, 8'hFF);
    rdb(`NFA_CHAN_A_CTRL);
    chk("ctrl_reserved", {24'h0, rd}, 32'h7);
    wr(8'hEB, 8'h5A);
    rdb(8'hEB);
    chk("unmapped_read", {24'h0, rd}, 32'h0);
    for (int s = 0; s < 4; s++) begin
      wr(`NFA_CHAN_A_CTRL, {5'h00, 2'(s), 1'b1});
      settle();
      chk("a_enable", {31'h0, a_en_q}, 32'h1);
      chk("a_select", {30'h0, a_sel_q}, 32'(s));
      chk("nco_mode", {30'h0, nco_q}, (s < 2) ? 32'(1 << s) : 32'h0);
    end
    wr(`NFA_CHAN_B_CTRL, 8'h07);
    settle();
    chk("clash", {31'h0, clash_q}, 32'h1);
    wr(`NFA_CHAN_B_CTRL, 8'h03);
    settle();
    chk("clash_off", {31'h0, clash_q}, 32'h0);
    chk("nco_mode_b", {30'h0, nco_q}, 32'h2);
    chk("b_enable", {31'h0, b_en_q}, 32'h1);
    chk("b_select", {30'h0, b_sel_q}, 32'h1);
    $display("TB: control decode done");
    for (int i = 0; i < 3; i++) wr(`NFA_CHAN_A_OFFSET + 8'(i), 8'h00 + ((i == 1) ? 8'h10 : 8'h00));
    rdb(`NFA_CHAN_A_OFFSET + 8'h01);
    chk("partial_word", {24'h0, rd}, 32'h0);
    wr(`NFA_CHAN_A_OFFSET + 8'h03, 8'h00);
    rdb(`NFA_CHAN_A_OFFSET + 8'h01);
    chk("full_word", {24'h0, rd}, 32'h10);
    for (int i = 0; i < 4; i++) wr(`NFA_CHAN_B_OFFSET + 8'(i), (i < 2) ? ((i == 0) ? 8'hFF : 8'hF0) : 8'h00);
    rdb(`NFA_CHAN_B_OFFSET);
    chk("b_word_msb", {24'h0, rd}, 32'hFF);
    wait_tick();
    chk("a_offset", a_off_q, 32'h0010_0000);
    chk("a_freq", a_freq_q, exp_freq(finit[3], 32'h0010_0000));
    chk("b_offset", b_off_q, 32'hFFF0_0000);
    chk("b_freq", b_freq_q, exp_freq(finit[1], 32'hFFF0_0000));
    $display("TB: offset apply done");
    wr(`NFA_CHAN_A_CTRL, 8'h06);
    settle();
    wait_tick();
    chk("a_off_disabled", a_off_q, 32'h0);
    chk("a_freq_disabled", a_freq_q, finit[3]);
    wr(`NFA_CHAN_A_CTRL, 8'h00);
    settle();
    wait_tick();
    chk("a_freq_ctrl_zero", a_freq_q, finit[0]);
    chk("a_off_ctrl_zero", a_off_q, 32'h0);
    chk("b_freq_kept", b_freq_q, exp_freq(finit[1], 32'hFFF0_0000));
    $display("TB: disable done");
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk("rst_b_offset", b_off_q, 32'h0);
    chk("rst_b_enable", {31'h0, b_en_q}, 32'h0);
    rdb(`NFA_CHAN_B_OFFSET);
    chk("rst_b_word", {24'h0, rd}, 32'h0);
    $display("TB: mid-run reset done");
    give_verdict();
  end
endmodule : nco_fine_frequency_adjust_tb
